// ==== pkg/pbm_pkg.sv ====
package pbm_pkg;

  // ----------------------------------------------------------------
  // Register indices and access port widths
  // ----------------------------------------------------------------
  localparam int          IDX_W       = 5;
  localparam int          DATA_W      = 16;
  localparam logic [4:0]  IDX_CONTROL = 5'h00;
  localparam logic [4:0]  IDX_STATUS  = 5'h01;

  // ----------------------------------------------------------------
  // Basic control field positions
  // ----------------------------------------------------------------
  localparam int CTL_SOFT_RESET = 15;
  localparam int CTL_LOOPBACK   = 14;
  localparam int CTL_SPEED_100  = 13;
  localparam int CTL_AN_ENABLE  = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_FULL_DUPLX = 8;
  localparam int CTL_COL_TEST   = 7;

  // ----------------------------------------------------------------
  // Basic status field positions and constant ability bits
  // ----------------------------------------------------------------
  localparam int           STS_AN_DONE    = 5;
  localparam int           STS_REM_FAULT  = 4;
  localparam int           STS_LINK_UP    = 2;
  localparam int           STS_JABBER     = 1;
  localparam logic [15:0]  STS_FIXED      = 16'h7809;
  localparam logic [15:0]  STS_FIXED_MASK = 16'hF809;
  localparam logic [15:0]  CTL_RSVD_MASK  = 16'h047F;

  // ----------------------------------------------------------------
  // Latched status slots
  // ----------------------------------------------------------------
  localparam int          LAT_N        = 3;
  localparam int          LAT_RFAULT   = 0;
  localparam int          LAT_LINK     = 1;
  localparam int          LAT_JABBER   = 2;
  localparam logic [2:0]  LAT_LOW_MASK = 3'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ       = 20_000_000;
  localparam int          SRST_TIME_NS = 200;
  localparam int          SRST_CYCLES  =
    (SRST_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0]  SRST_LAST    = 4'(SRST_CYCLES - 1);

  typedef enum logic [1:0] {
    PBM_ST_LOAD = 2'b00,
    PBM_ST_RUN  = 2'b01,
    PBM_ST_SRST = 2'b10
  } pbm_state_e;

endpackage : pbm_pkg

// ==== pkg/pbm_if.sv ====
interface pbm_if;
  logic [2:0] live;
  logic [2:0] held;
  logic       rd;
  logic       clr;

  modport regs  (output live, output rd, output clr, input held);
  modport latch (input live, input rd, input clr, output held);
endinterface : pbm_if

// ==== src/pbm_latch.sv ====
module pbm_latch (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  pbm_if.latch      lat
);

  // ----------------------------------------------------------------
  // Latched status bits
  // ----------------------------------------------------------------
  for (genvar i = 0; i < pbm_pkg::LAT_N; i++) begin : g_bit
    logic q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        q <= 1'b0;
      end else if (lat.clr) begin
        q <= 1'b0;
      end else if (pbm_pkg::LAT_LOW_MASK[i]) begin
        // A drop is held until read; a read reloads the live level.
        q <= lat.rd ? lat.live[i] : (q & lat.live[i]);
      end else begin
        // An event in the read cycle survives the clear.
        q <= lat.live[i] | (q & ~lat.rd);
      end
    end

    assign lat.held[i] = q;
  end

endmodule : pbm_latch

// ==== src/pbm_regs.sv ====
// Operation
// - Registers are reached only through the indexed management port.
// - Decimal index selects a register; control at 0, status at 1.
// - Survive-soft-reset marking applies only to the control bit 15 reset.
// - Writing control bit 15 starts soft reset; bit clears itself.
// - Control bit 14 selects loopback; resets to zero.
// - Control bit 13 selects 100 Mbps; ignored while negotiation enabled.
// - Control bit 12 enables negotiation, overriding manual speed and duplex.
// - Speed and negotiation enable reset values come from the speed strap.
// - Control bit 11 powers down; negotiation done reads zero meanwhile.
// - Writing control bit 9 restarts negotiation; bit clears itself.
// - Control bit 7 enables collision test; bits 10 and 6-0 read zero.
// - Status bits 14 to 11 read one; bit 15 reads zero.
// - Status bit 5 shows negotiation complete; resets to zero.
// - Status bit 4 latches a remote fault high; resets to zero.
// - Status bits 3 and 0 always read one.
// - Status bit 2 shows link, latching low; resets to zero.
// - Status bit 1 latches jabber high; status bits 10-6 read zero.
module pbm_regs (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        mgmt_req_i,
  input  wire logic        mgmt_wr_i,
  input  wire logic [4:0]  mgmt_idx_i,
  input  wire logic [15:0] mgmt_wdata_i,
  output logic             mgmt_ack_o,
  output logic [15:0]      mgmt_rdata_o,
  input  wire logic        speed_strap_i,
  input  wire logic        link_up_i,
  input  wire logic        remote_fault_i,
  input  wire logic        jabber_i,
  input  wire logic        an_complete_i,
  output logic             soft_reset_o,
  output logic             loopback_o,
  output logic             an_enable_o,
  output logic             an_restart_o,
  output logic             force_speed_100_o,
  output logic             force_full_duplex_o,
  output logic             power_down_o,
  output logic             col_test_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pbm_pkg::pbm_state_e state;
  logic [3:0]          srst_cnt;
  logic                loopback;
  logic                speed_100;
  logic                an_enable;
  logic                power_down;
  logic                full_duplex;
  logic                col_test;
  logic                an_done;
  logic                sel_ctrl;
  logic                sel_status;
  logic                wr_ctrl;
  logic                wr_ctrl_run;
  logic                rd_status;
  logic                rd_ctrl_q;
  logic                rd_status_q;
  logic [15:0]         ctrl_word;
  logic [15:0]         status_word;

  pbm_if lat_if ();

  // ----------------------------------------------------------------
  // Index decode
  // ----------------------------------------------------------------
  // The only path to the registers is this indexed port.
  assign sel_ctrl    = mgmt_idx_i == pbm_pkg::IDX_CONTROL;
  assign sel_status  = mgmt_idx_i == pbm_pkg::IDX_STATUS;
  assign wr_ctrl     = mgmt_req_i & mgmt_wr_i & sel_ctrl;
  assign wr_ctrl_run = wr_ctrl & (state == pbm_pkg::PBM_ST_RUN);
  assign rd_status   = mgmt_req_i & ~mgmt_wr_i & sel_status;

  // ----------------------------------------------------------------
  // Sequencer: strap load, run and soft reset
  // ----------------------------------------------------------------
  // The strap is sampled in the load state, one edge after reset release
  // and again after every soft reset.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= pbm_pkg::PBM_ST_LOAD;
    end else begin
      unique case (state)
        pbm_pkg::PBM_ST_LOAD: begin
          state <= pbm_pkg::PBM_ST_RUN;
        end
        pbm_pkg::PBM_ST_RUN: begin
          if (wr_ctrl && mgmt_wdata_i[pbm_pkg::CTL_SOFT_RESET]) begin
            state <= pbm_pkg::PBM_ST_SRST;
          end
        end
        pbm_pkg::PBM_ST_SRST: begin
          if (srst_cnt == pbm_pkg::SRST_LAST) begin
            state <= pbm_pkg::PBM_ST_LOAD;
          end
        end
        default: begin
          state <= pbm_pkg::PBM_ST_LOAD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      srst_cnt <= 4'h0;
    end else if (state == pbm_pkg::PBM_ST_SRST) begin
      srst_cnt <= srst_cnt + 4'h1;
    end else begin
      srst_cnt <= 4'h0;
    end
  end

  assign soft_reset_o = state == pbm_pkg::PBM_ST_SRST;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // No field of this register survives a soft reset, so the load state
  // restores every field.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loopback    <= 1'b0;
      speed_100   <= 1'b0;
      an_enable   <= 1'b0;
      power_down  <= 1'b0;
      full_duplex <= 1'b0;
      col_test    <= 1'b0;
    end else if (state == pbm_pkg::PBM_ST_LOAD) begin
      loopback    <= 1'b0;
      speed_100   <= speed_strap_i;
      an_enable   <= speed_strap_i;
      power_down  <= 1'b0;
      full_duplex <= 1'b0;
      col_test    <= 1'b0;
    end else if (wr_ctrl_run &&
                 !mgmt_wdata_i[pbm_pkg::CTL_SOFT_RESET]) begin
      // Reserved positions are simply not stored.
      loopback    <= mgmt_wdata_i[pbm_pkg::CTL_LOOPBACK];
      speed_100   <= mgmt_wdata_i[pbm_pkg::CTL_SPEED_100];
      an_enable   <= mgmt_wdata_i[pbm_pkg::CTL_AN_ENABLE];
      power_down  <= mgmt_wdata_i[pbm_pkg::CTL_POWER_DOWN];
      full_duplex <= mgmt_wdata_i[pbm_pkg::CTL_FULL_DUPLX];
      col_test    <= mgmt_wdata_i[pbm_pkg::CTL_COL_TEST];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      an_restart_o <= 1'b0;
    end else begin
      an_restart_o <= wr_ctrl_run
                      & mgmt_wdata_i[pbm_pkg::CTL_AN_RESTART]
                      & ~mgmt_wdata_i[pbm_pkg::CTL_SOFT_RESET];
    end
  end

  assign loopback_o          = loopback;
  assign an_enable_o         = an_enable;
  assign power_down_o        = power_down;
  assign col_test_o          = col_test;
  // Manual speed and duplex reach the line only without negotiation.
  assign force_speed_100_o   = speed_100 & ~an_enable;
  assign force_full_duplex_o = full_duplex & ~an_enable;

  // ----------------------------------------------------------------
  // Negotiation complete
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      an_done <= 1'b0;
    end else if (power_down || an_restart_o || !an_enable ||
                 state != pbm_pkg::PBM_ST_RUN) begin
      an_done <= 1'b0;
    end else begin
      an_done <= an_complete_i;
    end
  end

  // ----------------------------------------------------------------
  // Latched status conditions
  // ----------------------------------------------------------------
  assign lat_if.live[pbm_pkg::LAT_RFAULT] = remote_fault_i;
  assign lat_if.live[pbm_pkg::LAT_LINK]   = link_up_i;
  assign lat_if.live[pbm_pkg::LAT_JABBER] = jabber_i;
  assign lat_if.rd                        = rd_status;
  assign lat_if.clr                       = soft_reset_o;

  pbm_latch u_latch (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .lat       (lat_if.latch)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word                               = 16'h0000;
    ctrl_word[pbm_pkg::CTL_SOFT_RESET]      = soft_reset_o;
    ctrl_word[pbm_pkg::CTL_LOOPBACK]        = loopback;
    ctrl_word[pbm_pkg::CTL_SPEED_100]       = speed_100;
    ctrl_word[pbm_pkg::CTL_AN_ENABLE]       = an_enable;
    ctrl_word[pbm_pkg::CTL_POWER_DOWN]      = power_down;
    ctrl_word[pbm_pkg::CTL_FULL_DUPLX]      = full_duplex;
    ctrl_word[pbm_pkg::CTL_COL_TEST]        = col_test;
  end

  always_comb begin
    status_word                        = pbm_pkg::STS_FIXED;
    status_word[pbm_pkg::STS_AN_DONE]  = an_done;
    status_word[pbm_pkg::STS_REM_FAULT] =
      lat_if.held[pbm_pkg::LAT_RFAULT];
    status_word[pbm_pkg::STS_LINK_UP]  =
      lat_if.held[pbm_pkg::LAT_LINK];
    status_word[pbm_pkg::STS_JABBER]   =
      lat_if.held[pbm_pkg::LAT_JABBER];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mgmt_ack_o <= 1'b0;
    end else begin
      mgmt_ack_o <= mgmt_req_i;
    end
  end

  // Other populated indices live outside this block and read as zero.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mgmt_rdata_o <= 16'h0000;
    end else if (mgmt_req_i && !mgmt_wr_i && sel_ctrl) begin
      mgmt_rdata_o <= ctrl_word;
    end else if (rd_status) begin
      mgmt_rdata_o <= status_word;
    end else if (mgmt_req_i) begin
      mgmt_rdata_o <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_ctrl_q   <= 1'b0;
      rd_status_q <= 1'b0;
    end else begin
      rd_ctrl_q   <= mgmt_req_i & ~mgmt_wr_i & sel_ctrl;
      rd_status_q <= rd_status;
    end
  end

  a_ack_next_cycle: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    mgmt_req_i |=> mgmt_ack_o
  ) else $error("management request not acknowledged");

  a_srst_length: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_ctrl_run && mgmt_wdata_i[15]
    |=> soft_reset_o [*4] ##1 !soft_reset_o
  ) else $error("soft reset length wrong");

  a_strap_reload: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    state == pbm_pkg::PBM_ST_LOAD
    |=> an_enable_o == $past(speed_strap_i)
  ) else $error("negotiation enable not loaded from strap");

  a_restart_pulse: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_ctrl_run && mgmt_wdata_i[9] && !mgmt_wdata_i[15]
    |=> an_restart_o ##1 !an_restart_o
  ) else $error("restart not a single pulse");

  a_loopback_write: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_ctrl_run && !mgmt_wdata_i[15]
    |=> loopback_o == $past(mgmt_wdata_i[14])
  ) else $error("loopback write not taken");

  a_manual_ignored: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    an_enable_o |-> !force_speed_100_o && !force_full_duplex_o
  ) else $error("manual mode active under negotiation");

  a_status_fixed: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    rd_status_q |-> (mgmt_rdata_o & pbm_pkg::STS_FIXED_MASK)
                    == pbm_pkg::STS_FIXED && mgmt_rdata_o[10:6] == 5'h00
  ) else $error("status ability bits wrong");

  a_ctrl_reserved: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    rd_ctrl_q |-> (mgmt_rdata_o & pbm_pkg::CTL_RSVD_MASK) == 16'h0000
  ) else $error("control reserved bits not zero");

  a_jabber_held: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    jabber_i && !soft_reset_o ##1 rd_status && !soft_reset_o
    |=> mgmt_rdata_o[1]
  ) else $error("jabber event lost");

  a_link_drop_held: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !link_up_i ##1 rd_status |=> !mgmt_rdata_o[2]
  ) else $error("link drop not held low");

  a_pdown_no_done: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    power_down_o |=> !an_done
  ) else $error("negotiation complete during power down");

  a_srst_keeps_fields: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_ctrl_run && mgmt_wdata_i[pbm_pkg::CTL_SOFT_RESET]
    |=> $stable(loopback_o) && $stable(power_down_o) && $stable(col_test_o)
  ) else $error("soft reset write changed other control bits");

  a_load_defaults: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    state == pbm_pkg::PBM_ST_LOAD
    |=> !loopback_o && !power_down_o && !col_test_o && !full_duplex
  ) else $error("control fields not restored after reset");

  a_speed_strap: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    state == pbm_pkg::PBM_ST_LOAD
    |=> speed_100 == $past(speed_strap_i)
  ) else $error("speed select not loaded from strap");

  a_other_idx_zero: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    mgmt_req_i && !mgmt_wr_i && !sel_ctrl && !sel_status
    |=> mgmt_rdata_o == 16'h0000
  ) else $error("unpopulated index read not zero");

  a_srst_reads_one: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    mgmt_req_i && !mgmt_wr_i && sel_ctrl && soft_reset_o
    |=> mgmt_rdata_o[pbm_pkg::CTL_SOFT_RESET]
  ) else $error("reset bit not shown during soft reset");

endmodule : pbm_regs

// ==== verif/pbm_host_model.sv ====
module pbm_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        mgmt_ack_i,
  input  wire logic [15:0] mgmt_rdata_i,
  output logic             mgmt_req_o,
  output logic             mgmt_wr_o,
  output logic [4:0]       mgmt_idx_o,
  output logic [15:0]      mgmt_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    mgmt_req_o   = 1'h0;
    mgmt_wr_o    = 1'h0;
    mgmt_idx_o   = 5'h00;
    mgmt_wdata_o = 16'h0000;
  end

  // ----------------------------------------------------------------
  // Indexed access: a one-cycle request, the answer one cycle later.
  // ----------------------------------------------------------------
  // Released fields show the inverse so a stale value is never reused.
  task automatic access(input  logic        wr,
                        input  logic [4:0]  idx,
                        input  logic [15:0] wd,
                        output logic [15:0] rd,
                        output logic        ok);
    int n;
    rd = 16'hxxxx;
    ok = 1'h0;
    @(posedge sys_clk_i);
    #1;
    mgmt_req_o   = 1'h1;
    mgmt_wr_o    = wr;
    mgmt_idx_o   = idx;
    mgmt_wdata_o = wd;
    @(posedge sys_clk_i);
    #1;
    mgmt_req_o   = 1'h0;
    mgmt_wr_o    = ~wr;
    mgmt_idx_o   = ~idx;
    mgmt_wdata_o = ~wd;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge sys_clk_i);
      if (mgmt_ack_i === 1'h1) begin
        rd = mgmt_rdata_i;
        ok = 1'h1;
      end
    end
    #1;
  endtask : access
endmodule : pbm_host_model

// ==== verif/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk_i, arst_n_i, req, wr_en, ack;
  logic [4:0]  idx;
  logic [15:0] wdata, rdata;
  logic        strap, link_up, remote_fault, jabber, an_complete;
  logic        soft_reset, loopback, an_enable, an_restart;
  logic        force_100, force_fd, power_down, col_test;
  int          fails, checks, srst_cycles, restarts, r0;
  logic [15:0] lh_mask [2] = '{16'h0010, 16'h0002};
  logic [4:0]  spare [4]   = '{5'h02, 5'h06, 5'h11, 5'h1F};

  pbm_host_model host (.sys_clk_i(sys_clk_i), .mgmt_ack_i(ack),
    .mgmt_rdata_i(rdata), .mgmt_req_o(req), .mgmt_wr_o(wr_en),
    .mgmt_idx_o(idx), .mgmt_wdata_o(wdata));

  pbm_regs DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .mgmt_req_i(req), .mgmt_wr_i(wr_en), .mgmt_idx_i(idx),
    .mgmt_wdata_i(wdata), .mgmt_ack_o(ack), .mgmt_rdata_o(rdata),
    .speed_strap_i(strap), .link_up_i(link_up),
    .remote_fault_i(remote_fault), .jabber_i(jabber),
    .an_complete_i(an_complete), .soft_reset_o(soft_reset),
    .loopback_o(loopback), .an_enable_o(an_enable),
    .an_restart_o(an_restart), .force_speed_100_o(force_100),
    .force_full_duplex_o(force_fd), .power_down_o(power_down),
    .col_test_o(col_test));

  always #25 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    if (soft_reset === 1'h1) srst_cycles++;
    if (an_restart === 1'h1) restarts++;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, exp, mask);
    checks++;
    if ((got & mask) !== (exp & mask)) begin
      fails++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    host.access(1'h1, i, d, r, ok);
    chk_bit(ok, 1'h1);
  endtask : wr

  task automatic rd(input logic [4:0] i, input logic [15:0] e, m);
    logic [15:0] r;
    logic        ok;
    host.access(1'h0, i, 16'h0000, r, ok);
    chk_bit(ok, 1'h1);
    chk_word(r, e, m);
  endtask : rd

  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #(5000 * 50);
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i    = 1'h0;
    arst_n_i     = 1'h0;
    strap        = 1'h1;
    link_up      = 1'h0;
    remote_fault = 1'h0;
    jabber       = 1'h0;
    an_complete  = 1'h0;
    cyc(10);
    arst_n_i = 1'h1;
    cyc(2);
    rd(5'h00, 16'h3000, 16'hFFFF);
    chk_bit(an_enable, 1'h1);
    chk_bit(force_100, 1'h0);
    chk_bit(loopback, 1'h0);
    rd(5'h01, 16'h7809, 16'hFFFF);
    wr(5'h00, 16'h65FF);
    rd(5'h00, 16'h6180, 16'hFFFF);
    chk_bit(loopback, 1'h1);
    chk_bit(force_100, 1'h1);
    chk_bit(force_fd, 1'h1);
    chk_bit(col_test, 1'h1);
    chk_bit(an_enable, 1'h0);
    wr(5'h00, 16'h0800);
    chk_bit(power_down, 1'h1);
    wr(5'h00, 16'h1100);
    chk_bit(power_down, 1'h0);
    chk_bit(force_fd, 1'h0);
    r0 = restarts;
    wr(5'h00, 16'h1300);
    cyc(2);
    chk_bit(restarts == r0 + 1, 1'h1);
    rd(5'h00, 16'h1100, 16'hFFFF);
    an_complete = 1'h1;
    cyc(3);
    rd(5'h01, 16'h0020, 16'h0020);
    wr(5'h00, 16'h1900);
    cyc(3);
    rd(5'h01, 16'h0000, 16'h0020);
    wr(5'h00, 16'h1100);
    link_up = 1'h1;
    rd(5'h01, 16'h0000, 16'h0000);
    rd(5'h01, 16'h0004, 16'h0004);
    link_up = 1'h0;
    cyc(2);
    link_up = 1'h1;
    cyc(2);
    rd(5'h01, 16'h0000, 16'h0004);
    rd(5'h01, 16'h0004, 16'h0004);
    foreach (lh_mask[i]) begin
      remote_fault = lh_mask[i][4];
      jabber       = lh_mask[i][1];
      cyc(2);
      remote_fault = 1'h0;
      jabber       = 1'h0;
      cyc(2);
      rd(5'h01, lh_mask[i], lh_mask[i]);
      rd(5'h01, 16'h0000, lh_mask[i]);
    end
    foreach (spare[i]) begin
      wr(spare[i], 16'hFFFF);
      rd(spare[i], 16'h0000, 16'hFFFF);
    end
    wr(5'h01, 16'hFFFF);
    rd(5'h01, 16'h7809, 16'hFFC9);
    strap = 1'h0;
    r0 = srst_cycles;
    wr(5'h00, 16'hC000);
    rd(5'h00, 16'h8000, 16'h8000);
    cyc(5);
    chk_bit(srst_cycles == r0 + 4, 1'h1);
    chk_bit(loopback, 1'h0);
    rd(5'h00, 16'h0000, 16'hFFFF);
    wr(5'h00, 16'h4000);
    chk_bit(loopback, 1'h1);
    arst_n_i = 1'h0;
    cyc(2);
    chk_bit(loopback, 1'h0);
    arst_n_i = 1'h1;
    cyc(2);
    rd(5'h01, 16'h7809, 16'hFFFF);
    rd(5'h00, 16'h0000, 16'hFFFF);
    tally_and_finish();
  end
endmodule : testbench
